/* verilog/switch_port_pkg.sv */
// Purpose: Shared constants for the switch host port and serial lane block
// Assumes: One 10 MHz core clock; all pins are asynchronous to it
// Notes: Map pages are selected by address bits 11:4, lane by bits 3:0
package switch_port_pkg;
  localparam int LANES = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int LANE_W = 4;
  localparam int FRAME_CNT_W = 10;
  localparam int FIFO_DEPTH = 32;
  // Core clock period and the host timing figures the far side keeps
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_HOLD_US = 1000;
  localparam int FIRST_ACCESS_US = 600;
  localparam int FIRST_ACCESS_CYC = (FIRST_ACCESS_US * 1000) / CLK_PERIOD_NS;
  // Lane rate codes held in bits 2:0 of each lane control word
  localparam logic [2:0] RATE_2M = 3'h0;
  localparam logic [2:0] RATE_4M = 3'h1;
  localparam logic [2:0] RATE_8M = 3'h2;
  // Slot index shift per rate: 32, 64 or 128 channels in one frame
  localparam logic [1:0] SHIFT_2M = 2'h2;
  localparam logic [1:0] SHIFT_4M = 2'h1;
  localparam logic [1:0] SHIFT_8M = 2'h0;
  // Address pages (address bits 11:4) and single-word addresses
  localparam logic [7:0] IN_CTRL_PAGE = 8'h00;
  localparam logic [7:0] OUT_CTRL_PAGE = 8'h01;
  localparam logic [7:0] CONN_PAGE = 8'h10;
  localparam logic [11:0] DATA_MEM_ADDR = 12'h020;
  localparam logic [11:0] STATUS_ADDR = 12'h021;
  localparam logic [11:0] CAPTURE_ADDR = 12'h022;
  // Field positions
  localparam int CONN_FLOAT_BIT = 8;
  localparam int CAP_EN_BIT = 4;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage

/* verilog/sample_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Read data come from a register that always shows the head entry
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [PW:0] count_r, count_nxt;
  logic [WIDTH-1:0] head_r, head_nxt;
  logic push, pop;

  // Honest full and empty flags
  assign in_ready_out = (count_r != DEPTH[PW:0]);
  assign out_valid_out = (count_r != '0);
  assign out_data_out = head_r;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;

  // Pointer, count and head-of-queue next values
  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt = count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    // Write-through when the new head is being written this cycle
    head_nxt = (push && (wr_ptr_r == rd_ptr_nxt)) ? in_data_in : mem_r[rd_ptr_nxt];
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      head_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      head_r <= head_nxt;
    end
  end

  // Storage array
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end
endmodule // sample_fifo

/* verilog/switch_host_port.sv */
// Purpose: Host port, lane rate control, float indicators and serial lanes
// Assumes: Pins are asynchronous and pass two flip-flops before use
// Notes: One tick of the lane bit clock equals one bit time at the top rate
// Functional notes
// - Floated lane slot drives float flag high
// - Driving lane slot drives float flag low
// - Sixteen-bit two-way host data bus
// - Acknowledge low marks completed transfer, else floats
// - Direction input chooses read or write
// - Access only while strobe and select low
// - Twelve-bit address picks memories and registers
// - Each input lane has its own rate control
// - Lanes carry 32, 64 or 128 channels
// - Reset pin floats lanes, flags forced high
// - Reset clears registers and counters
// - Drive gate low floats lanes, flags high
// - Register, connection read/write; data memory read-only
`timescale 1ns/100ps
module switch_host_port (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic stream_output_drive_gate_in,
  input wire logic lane_clk_in,
  input wire logic frame_pulse_n_in,
  input wire logic select_n_in,
  input wire logic strobe_n_in,
  input wire logic read_not_write_in,
  input wire logic [11:0] host_address_lines_in,
  input wire logic [15:0] host_data_lines_in,
  output logic [15:0] host_data_lines_out,
  output logic host_data_lines_oe_n_out,
  output logic transfer_acknowledge_n_out,
  output logic transfer_acknowledge_n_oe_n_out,
  input wire logic [15:0] serial_input_lane_in,
  output logic [15:0] serial_out_lane_out,
  output logic [15:0] serial_out_lane_oe_n_out,
  output logic [15:0] output_float_flag_out
);
  localparam int N = switch_port_pkg::LANES;
  localparam int SW = 7 + switch_port_pkg::ADDR_W + 2 * switch_port_pkg::DATA_W;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } host_state_type;

  logic [SW-1:0] meta_r, sync_r, pin_vec;
  logic ck_s, fp_n_s, reset_n_s, gate_s, cs_n_s, ds_n_s, rw_s;
  logic [11:0] addr_s;
  logic [15:0] din_s;
  logic [15:0] lane_s;
  logic ck_d_r, tick;
  logic dev_rst;
  logic [switch_port_pkg::FRAME_CNT_W-1:0] frame_r, frame_nxt;
  host_state_type state_r, state_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic doe_n_r, doe_n_nxt, ack_oe_n_r, ack_oe_n_nxt;
  logic wr_en, pop, access;
  logic [15:0] in_ctrl_r [N];
  logic [15:0] out_ctrl_r [N];
  logic [15:0] conn_r [N];
  logic [N-1:0] done_w;
  logic [7:0] byte_w [N];
  logic [6:0] chan_w [N];
  logic [15:0] cap_r, cap_nxt;
  logic ovf_r, ovf_nxt;
  logic push, fifo_ready, fifo_valid;
  logic [15:0] fifo_data;
  logic [3:0] cap_lane;
  logic [15:0] rd_mux;

  // Two-stage synchroniser for every pin
  assign pin_vec = {lane_clk_in, frame_pulse_n_in, reset_n_in, stream_output_drive_gate_in,
                    select_n_in, strobe_n_in, read_not_write_in, host_address_lines_in,
                    host_data_lines_in, serial_input_lane_in};
  always_ff @(posedge core_clk_in) begin
    meta_r <= pin_vec;
    sync_r <= meta_r;
  end
  assign {ck_s, fp_n_s, reset_n_s, gate_s, cs_n_s, ds_n_s, rw_s, addr_s, din_s, lane_s} = sync_r;

  // Device reset from the core reset or the reset pin
  assign dev_rst = rst_in | ~reset_n_s;
  assign tick = ck_s & ~ck_d_r;

  // Frame slot counter restarted by the frame pulse
  always_comb begin
    frame_nxt = frame_r;
    if (tick) begin
      frame_nxt = fp_n_s ? frame_r + 1'b1 : '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      ck_d_r <= 1'b1; // No false tick if the lane clock idles high
      frame_r <= '0;
    end else begin
      ck_d_r <= ck_s;
      frame_r <= frame_nxt;
    end
  end

  // Address decode and read data selection
  assign access = ~cs_n_s & ~ds_n_s;
  always_comb begin
    rd_mux = switch_port_pkg::REG_RESET;
    unique case (addr_s[11:4])
      switch_port_pkg::IN_CTRL_PAGE: rd_mux = in_ctrl_r[addr_s[3:0]];
      switch_port_pkg::OUT_CTRL_PAGE: rd_mux = out_ctrl_r[addr_s[3:0]];
      switch_port_pkg::CONN_PAGE: rd_mux = conn_r[addr_s[3:0]];
      default: begin
        if (addr_s == switch_port_pkg::DATA_MEM_ADDR) begin
          rd_mux = fifo_valid ? fifo_data : switch_port_pkg::REG_RESET; // Empty queue reads 0
        end else if (addr_s == switch_port_pkg::STATUS_ADDR) begin
          rd_mux[switch_port_pkg::STAT_VALID_BIT] = fifo_valid;
          rd_mux[switch_port_pkg::STAT_OVF_BIT] = ovf_r;
        end else if (addr_s == switch_port_pkg::CAPTURE_ADDR) begin
          rd_mux = cap_r;
        end
      end
    endcase
  end

  // Host access sequencer
  always_comb begin
    state_nxt = state_r;
    dout_nxt = dout_r;
    doe_n_nxt = doe_n_r;
    ack_oe_n_nxt = ack_oe_n_r;
    wr_en = 1'b0;
    pop = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (access) begin
          if (rw_s) begin
            dout_nxt = rd_mux;
            doe_n_nxt = 1'b0;
            pop = (addr_s == switch_port_pkg::DATA_MEM_ADDR) & fifo_valid;
          end else begin
            wr_en = 1'b1;
          end
          ack_oe_n_nxt = 1'b0;
          state_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!access) begin
          doe_n_nxt = 1'b1;
          ack_oe_n_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      state_r <= ST_IDLE;
      dout_r <= switch_port_pkg::REG_RESET;
      doe_n_r <= 1'b1;
      ack_oe_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      dout_r <= dout_nxt;
      doe_n_r <= doe_n_nxt;
      ack_oe_n_r <= ack_oe_n_nxt;
    end
  end

  // Capture selection and sticky overflow; a new overflow beats the clear
  assign cap_lane = cap_r[3:0];
  assign push = done_w[cap_lane] & cap_r[switch_port_pkg::CAP_EN_BIT];
  always_comb begin
    cap_nxt = cap_r;
    ovf_nxt = ovf_r;
    if (wr_en && addr_s == switch_port_pkg::CAPTURE_ADDR) begin
      cap_nxt = din_s;
    end
    if (wr_en && addr_s == switch_port_pkg::STATUS_ADDR && din_s[switch_port_pkg::STAT_OVF_BIT]) begin
      ovf_nxt = 1'b0;
    end
    if (push && !fifo_ready) begin
      ovf_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (dev_rst) begin
      cap_r <= switch_port_pkg::REG_RESET;
      ovf_r <= 1'b0;
    end else begin
      cap_r <= cap_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // Per-lane control words, input shifter and output slot driver
  for (genvar i = 0; i < N; i++) begin : g_lane
    logic [15:0] ic_nxt, oc_nxt, cm_nxt;
    logic [7:0] ish_r, ish_nxt;
    logic so_r, so_nxt, soe_n_r, soe_n_nxt, flt_r, flt_nxt;
    logic [1:0] ish_amt, osh_amt;
    logic [switch_port_pkg::FRAME_CNT_W-1:0] islot, oslot;
    logic istep, ostep;

    // Rate code to slot shift; unknown codes run at the lowest rate
    always_comb begin
      unique case (in_ctrl_r[i][2:0])
        switch_port_pkg::RATE_8M: ish_amt = switch_port_pkg::SHIFT_8M;
        switch_port_pkg::RATE_4M: ish_amt = switch_port_pkg::SHIFT_4M;
        default: ish_amt = switch_port_pkg::SHIFT_2M;
      endcase
      unique case (out_ctrl_r[i][2:0])
        switch_port_pkg::RATE_8M: osh_amt = switch_port_pkg::SHIFT_8M;
        switch_port_pkg::RATE_4M: osh_amt = switch_port_pkg::SHIFT_4M;
        default: osh_amt = switch_port_pkg::SHIFT_2M;
      endcase
    end

    // Slot index: 32, 64 or 128 channels of eight bits per frame
    assign islot = frame_r >> ish_amt;
    assign oslot = frame_r >> osh_amt;
    assign istep = tick & ((frame_r & ((10'h1 << ish_amt) - 10'h1)) == '0);
    assign ostep = tick & ((frame_r & ((10'h1 << osh_amt) - 10'h1)) == '0);
    assign done_w[i] = istep & (islot[2:0] == switch_port_pkg::LAST_BIT);
    assign byte_w[i] = {ish_r[6:0], lane_s[i]};
    assign chan_w[i] = islot[9:3];

    always_comb begin
      ic_nxt = in_ctrl_r[i];
      oc_nxt = out_ctrl_r[i];
      cm_nxt = conn_r[i];
      if (wr_en && addr_s[3:0] == 4'(i)) begin
        if (addr_s[11:4] == switch_port_pkg::IN_CTRL_PAGE) ic_nxt = din_s;
        if (addr_s[11:4] == switch_port_pkg::OUT_CTRL_PAGE) oc_nxt = din_s;
        if (addr_s[11:4] == switch_port_pkg::CONN_PAGE) cm_nxt = din_s;
      end
      ish_nxt = istep ? byte_w[i] : ish_r;
      so_nxt = ostep ? conn_r[i][switch_port_pkg::LAST_BIT - oslot[2:0]] : so_r;
      // Drive only when the gate pin is high and the slot is not floated
      if (!gate_s || conn_r[i][switch_port_pkg::CONN_FLOAT_BIT]) begin
        soe_n_nxt = 1'b1;
        flt_nxt = 1'b1;
      end else begin
        soe_n_nxt = 1'b0;
        flt_nxt = 1'b0;
      end
    end

    always_ff @(posedge core_clk_in) begin
      if (dev_rst) begin
        in_ctrl_r[i] <= switch_port_pkg::REG_RESET;
        out_ctrl_r[i] <= switch_port_pkg::REG_RESET;
        conn_r[i] <= switch_port_pkg::REG_RESET;
        ish_r <= '0;
        so_r <= 1'b0;
        soe_n_r <= 1'b1;
        flt_r <= 1'b1;
      end else begin
        in_ctrl_r[i] <= ic_nxt;
        out_ctrl_r[i] <= oc_nxt;
        conn_r[i] <= cm_nxt;
        ish_r <= ish_nxt;
        so_r <= so_nxt;
        soe_n_r <= soe_n_nxt;
        flt_r <= flt_nxt;
      end
    end

    assign serial_out_lane_out[i] = so_r;
    assign serial_out_lane_oe_n_out[i] = soe_n_r;
    assign output_float_flag_out[i] = flt_r;
  end

  // Captured channel bytes queue up for data memory reads
  sample_fifo #(
    .WIDTH(16),
    .DEPTH(switch_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rst_in(dev_rst),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in({1'b1, chan_w[cap_lane], byte_w[cap_lane]}),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_data)
  );

  assign host_data_lines_out = dout_r;
  assign host_data_lines_oe_n_out = doe_n_r;
  assign transfer_acknowledge_n_out = ack_oe_n_r; // Driven level is low while acknowledging
  assign transfer_acknowledge_n_oe_n_out = ack_oe_n_r;
endmodule // switch_host_port

/* dv/switch_host_port_chk.sv */
// Purpose: Concurrent checks on the host port and lane pins of the switch block
// Assumes: Pins pass two sync stages; figures follow the hand-over latencies
// Notes: Attached by bind at the foot of this file
`timescale 1ns/100ps
module switch_host_port_chk (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  input wire logic stream_output_drive_gate_in,
  input wire logic select_n_in,
  input wire logic strobe_n_in,
  input wire logic read_not_write_in,
  input wire logic host_data_lines_oe_n_out,
  input wire logic transfer_acknowledge_n_out,
  input wire logic transfer_acknowledge_n_oe_n_out,
  input wire logic [15:0] serial_out_lane_oe_n_out,
  input wire logic [15:0] output_float_flag_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Host access is open while select and strobe are both low
  wire acc = !select_n_in && !strobe_n_in;
  // Flags mirror lane drive state, lane by lane
  a_flag_tracks_drive: assert property (output_float_flag_out == serial_out_lane_oe_n_out)
    else $error("float flag differs from lane drive state");
  a_gate_floats_all: assert property ((!stream_output_drive_gate_in)[*4] |=>
    &output_float_flag_out && &serial_out_lane_oe_n_out) else $error("gate low left a lane driven");
  a_pin_reset_floats: assert property ((!reset_n_in)[*4] |=>
    &output_float_flag_out && &serial_out_lane_oe_n_out) else $error("reset pin left a lane driven");
  a_pin_reset_host: assert property ((!reset_n_in)[*4] |=>
    transfer_acknowledge_n_oe_n_out && host_data_lines_oe_n_out) else $error("reset left bus driven");
  a_ack_value_low: assert property (!transfer_acknowledge_n_oe_n_out |->
    !transfer_acknowledge_n_out) else $error("acknowledge drives a high level");
  a_ack_needs_access: assert property ($fell(transfer_acknowledge_n_oe_n_out) |->
    $past(acc, 1) && $past(acc, 2)) else $error("acknowledge without select and strobe");
  a_ack_stands_held: assert property (acc[*3] ##0 !transfer_acknowledge_n_oe_n_out |=>
    !transfer_acknowledge_n_oe_n_out) else $error("acknowledge dropped during access");
  a_ack_released_idle: assert property ((!acc)[*4] |=>
    transfer_acknowledge_n_oe_n_out && host_data_lines_oe_n_out) else $error("bus held after release");
  a_data_with_ack: assert property (!host_data_lines_oe_n_out |-> !transfer_acknowledge_n_oe_n_out)
    else $error("data driven outside an access");
  a_write_no_drive: assert property ((!read_not_write_in)[*6] |-> host_data_lines_oe_n_out)
    else $error("data driven during a write");
  // Main scenarios reached
  c_read_done: cover property ($fell(host_data_lines_oe_n_out));
  c_write_done: cover property ($fell(transfer_acknowledge_n_oe_n_out) && !read_not_write_in);
  c_all_float: cover property ($rose(&output_float_flag_out));
endmodule // switch_host_port_chk
bind switch_host_port switch_host_port_chk switch_host_port_chk_i (.core_clk_in, .rst_in,
  .reset_n_in, .stream_output_drive_gate_in, .select_n_in, .strobe_n_in, .read_not_write_in,
  .host_data_lines_oe_n_out, .transfer_acknowledge_n_out, .transfer_acknowledge_n_oe_n_out,
  .serial_out_lane_oe_n_out, .output_float_flag_out);

/* dv/host_master.sv */
// Purpose: Behavioural microprocessor master for the switch host port
// Assumes: Acknowledge level comes in already resolved with its pull-up
// Notes: Holds the request until acknowledge is sampled low or 20 clocks pass
`timescale 1ns/100ps
module host_master (
  input wire logic core_clk_in,
  input wire logic [15:0] bus_in,
  input wire logic ack_n_in,
  output logic select_n_out,
  output logic strobe_n_out,
  output logic read_not_write_out,
  output logic [11:0] address_out,
  output logic [15:0] wdata_out,
  output logic drive_out
);
  // Idle bus at time zero
  initial begin
    select_n_out = 1'b1;
    strobe_n_out = 1'b1;
    read_not_write_out = 1'b0;
    address_out = 12'h000;
    wdata_out = 16'h0000;
    drive_out = 1'b0;
  end
  // One word transfer, bounded wait for acknowledge
  task automatic access(input logic rd, input logic [11:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 16'h0000;
    @(posedge core_clk_in);
    select_n_out <= 1'b0;
    strobe_n_out <= 1'b0;
    read_not_write_out <= rd;
    address_out <= a;
    wdata_out <= d;
    drive_out <= !rd;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge core_clk_in);
      if (ack_n_in === 1'b0) begin
        ok = 1'b1;
        q = bus_in;
      end
    end
    select_n_out <= 1'b1;
    strobe_n_out <= 1'b1;
    drive_out <= 1'b0;
    repeat (4) @(posedge core_clk_in); // Release must be seen before the next access
  endtask
endmodule // host_master

/* dv/switch_host_port_bench.sv */
// Purpose: Self-checking bench for the switch host port and serial lanes
// Assumes: Host master model drives the port; bench drives lanes and pins
// Notes: Reset pin hold and first-access wait keep the host's timing figures
`timescale 1ns/100ps
module switch_host_port_bench;
  logic core_clk_in, rst_in, reset_n_in, stream_output_drive_gate_in, lane_clk_in;
  logic frame_pulse_n_in, select_n_in, strobe_n_in, read_not_write_in, drive;
  logic host_data_lines_oe_n_out, transfer_acknowledge_n_out, transfer_acknowledge_n_oe_n_out;
  logic [11:0] host_address_lines_in;
  logic [15:0] host_data_lines_out, serial_input_lane_in, serial_out_lane_out, wdata;
  logic [15:0] serial_out_lane_oe_n_out, output_float_flag_out, q;
  int err_total = 0;
  int check_count = 0;
  localparam int RESET_HOLD_CYC =
    (switch_port_pkg::RESET_HOLD_US * 1000) / switch_port_pkg::CLK_PERIOD_NS + 1;
  // Wire levels: released data bus shows the inverse, acknowledge pulled up
  wire logic [15:0] host_data_lines_in = !host_data_lines_oe_n_out ? host_data_lines_out :
    (drive ? wdata : ~host_data_lines_out);
  wire logic ack_wire = transfer_acknowledge_n_oe_n_out ? 1'b1 : transfer_acknowledge_n_out;
  switch_host_port switch_host_port_i (.core_clk_in, .rst_in, .reset_n_in,
    .stream_output_drive_gate_in, .lane_clk_in, .frame_pulse_n_in, .select_n_in, .strobe_n_in,
    .read_not_write_in, .host_address_lines_in, .host_data_lines_in, .host_data_lines_out,
    .host_data_lines_oe_n_out, .transfer_acknowledge_n_out, .transfer_acknowledge_n_oe_n_out,
    .serial_input_lane_in, .serial_out_lane_out, .serial_out_lane_oe_n_out, .output_float_flag_out);
  host_master host_master_i (.core_clk_in(core_clk_in), .bus_in(host_data_lines_in),
    .ack_n_in(ack_wire), .select_n_out(select_n_in), .strobe_n_out(strobe_n_in),
    .read_not_write_out(read_not_write_in), .address_out(host_address_lines_in),
    .wdata_out(wdata), .drive_out(drive));
  // Clock
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic rd, input logic [11:0] a, input logic [15:0] d);
    logic ok;
    host_master_i.access(rd, a, d, q, ok);
    if (!ok) begin
      err_total++;
      finish_test();
    end
  endtask
  // Per-lane rate codes written and read back
  task automatic t_rates();
    logic [2:0] c;
    for (int i = 0; i < 16; i++) begin
      c = (i % 3 == 0) ? switch_port_pkg::RATE_2M : (i % 3 == 1) ? switch_port_pkg::RATE_4M :
        switch_port_pkg::RATE_8M;
      xfer(1'b0, {switch_port_pkg::IN_CTRL_PAGE, 4'(i)}, {13'h0000, c});
      xfer(1'b1, {switch_port_pkg::IN_CTRL_PAGE, 4'(i)}, 16'h0000);
      chk("input rate", q, {13'h0000, c});
      xfer(1'b0, {switch_port_pkg::OUT_CTRL_PAGE, 4'(i)}, {13'h0000, c});
      xfer(1'b1, {switch_port_pkg::OUT_CTRL_PAGE, 4'(i)}, 16'h0000);
      chk("output rate", q, {13'h0000, c});
    end
  endtask
  // Lane float via connection word, then drive gate
  task automatic t_float();
    xfer(1'b0, {switch_port_pkg::CONN_PAGE, 4'h5}, 16'h0100);
    xfer(1'b1, {switch_port_pkg::CONN_PAGE, 4'h5}, 16'h0000);
    chk("connection word", q, 16'h0100);
    chk("float flags", output_float_flag_out, 16'h0020);
    stream_output_drive_gate_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    chk("gated flags", output_float_flag_out, 16'hffff);
    chk("gated drive", serial_out_lane_oe_n_out, 16'hffff);
    stream_output_drive_gate_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    chk("ungated drive", serial_out_lane_oe_n_out, 16'h0020);
    xfer(1'b0, {switch_port_pkg::CONN_PAGE, 4'h5}, 16'h0000);
  endtask
  // Data memory read-only, unmapped read
  task automatic t_readonly();
    xfer(1'b0, switch_port_pkg::DATA_MEM_ADDR, 16'hbeef);
    xfer(1'b1, switch_port_pkg::DATA_MEM_ADDR, 16'h0000);
    chk("empty data memory", q, 16'h0000);
    xfer(1'b1, 12'hfff, 16'h0000);
    chk("unmapped read", q, 16'h0000);
  endtask
  // One lane clock rise with lane data and frame pulse set two clocks ahead
  task automatic lane_tick(input logic fp_n, input logic [15:0] d);
    @(posedge core_clk_in);
    serial_input_lane_in <= d;
    frame_pulse_n_in <= fp_n;
    lane_clk_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    lane_clk_in <= 1'b1;
    @(posedge core_clk_in);
  endtask
  // Lane 5 output at the top rate: connection byte leaves MSB first after the frame pulse
  task automatic t_serial_out();
    logic [15:0] bit_exp;
    xfer(1'b0, {switch_port_pkg::OUT_CTRL_PAGE, 4'h5}, {13'h0000, switch_port_pkg::RATE_8M});
    xfer(1'b0, {switch_port_pkg::CONN_PAGE, 4'h5}, 16'h00a5);
    for (int k = 0; k < 9; k++) begin
      lane_tick(k != 0, 16'h0000);
      repeat (3) @(posedge core_clk_in);
      bit_exp = {15'h0000, 1'(8'ha5 >> (8 - k))};
      if (k > 0) chk("serial out bit", {15'h0000, serial_out_lane_out[5]}, bit_exp);
    end
    chk("serial out drive", serial_out_lane_oe_n_out, 16'h0000);
  endtask
  // One 32-channel frame plus one byte on lane 2: fill, overflow, drain
  task automatic t_capture();
    logic [7:0] b;
    xfer(1'b0, {switch_port_pkg::IN_CTRL_PAGE, 4'h2}, {13'h0000, switch_port_pkg::RATE_2M});
    xfer(1'b0, switch_port_pkg::CAPTURE_ADDR, 16'h0012);
    for (int t = 0; t < 1056; t++) begin
      b = 8'((t % 1024) / 32) ^ 8'h5a;
      lane_tick(t != 0, {13'h0000, b[7 - ((t % 32) / 4)], 2'h0});
    end
    lane_clk_in <= 1'b0;
    xfer(1'b1, switch_port_pkg::STATUS_ADDR, 16'h0000);
    chk("full status", q, 16'h0003);
    for (int ch = 0; ch < 32; ch++) begin
      xfer(1'b1, switch_port_pkg::DATA_MEM_ADDR, 16'h0000);
      chk("captured byte", q, {1'b1, 7'(ch), 8'(ch) ^ 8'h5a});
    end
    xfer(1'b1, switch_port_pkg::STATUS_ADDR, 16'h0000);
    chk("drained status", q, 16'h0002);
    xfer(1'b1, switch_port_pkg::DATA_MEM_ADDR, 16'h0000);
    chk("drained data memory", q, 16'h0000);
    xfer(1'b0, switch_port_pkg::STATUS_ADDR, 16'h0002);
    xfer(1'b1, switch_port_pkg::STATUS_ADDR, 16'h0000);
    chk("cleared status", q, 16'h0000);
  endtask
  // Device reset pin floats lanes and clears registers
  task automatic t_pin_reset();
    reset_n_in <= 1'b0;
    repeat (RESET_HOLD_CYC) @(posedge core_clk_in);
    chk("reset flags", output_float_flag_out, 16'hffff);
    chk("reset drive", serial_out_lane_oe_n_out, 16'hffff);
    chk("reset lane data", serial_out_lane_out, 16'h0000);
    reset_n_in <= 1'b1;
    repeat (switch_port_pkg::FIRST_ACCESS_CYC) @(posedge core_clk_in);
    xfer(1'b1, {switch_port_pkg::IN_CTRL_PAGE, 4'h1}, 16'h0000);
    chk("cleared rate", q, switch_port_pkg::REG_RESET);
    xfer(1'b1, switch_port_pkg::CAPTURE_ADDR, 16'h0000);
    chk("cleared capture", q, switch_port_pkg::REG_RESET);
  endtask
  // Main sequence
  initial begin
    rst_in = 1'b1;
    reset_n_in = 1'b1;
    stream_output_drive_gate_in = 1'b1;
    lane_clk_in = 1'b0;
    frame_pulse_n_in = 1'b1;
    serial_input_lane_in = 16'h0000;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (switch_port_pkg::FIRST_ACCESS_CYC) @(posedge core_clk_in);
    t_rates();
    t_float();
    t_readonly();
    t_capture();
    t_serial_out();
    t_pin_reset();
    finish_test();
  end
endmodule // switch_host_port_bench
